//--- rx_regs_params.svh
/*
 * Offsets, field positions, reset values and limits of the receive-mode
 * host register bank. Assumes the includer uses 16-bit register addresses.
 */
`ifndef RX_REGS_PARAMS_SVH
`define RX_REGS_PARAMS_SVH

// ===========================================================
// register offsets
`define OFS_FAULT_LATCH 16'h0090
`define OFS_COMM_LATCH 16'h0091
`define OFS_STREAM_LATCH 16'h0092
`define OFS_FAULT_CLEAR 16'h0094
`define OFS_COMM_CLEAR 16'h0095
`define OFS_STREAM_CLEAR 16'h0096
`define OFS_FAULT_STATUS 16'h009C
`define OFS_COMM_STATUS 16'h009D
`define OFS_STREAM_STATUS 16'h009E
`define OFS_COMMAND 16'h00A0
`define OFS_VOUT_LOW 16'h00AA
`define OFS_VOUT_HIGH 16'h00AB
`define OFS_ILIM 16'h00B2
`define OFS_RECT_THR 16'h00B3

// ===========================================================
// command register bit positions
`define CMD_OUT_ON 0
`define CMD_OUT_OFF 1
`define CMD_SEND_MSG 2
`define CMD_SEND_WAIT 3
`define CMD_SEND_TERM 4
`define CMD_SEND_STREAM 5

// ===========================================================
// status widths
`define FAULT_BITS 8
`define COMM_BITS 6
`define STREAM_BITS 4

// ===========================================================
// scaling and limits of the configuration registers
`define VOUT_STEP_MV 25
`define ILIM_STEP_MA 100
`define RECT_THR_STEP_MV 100
`define ILIM_MIN_CODE 8'h01
`define ILIM_MAX_CODE 8'h19

// ===========================================================
// reset values
`define VOUT_RST 16'h0000
`define ILIM_RST 8'h0A
`define RECT_THR_RST 8'h00

`endif

//--- rx_regs_pkg.sv
/*
 * Types of the receive-mode host register bank.
 * Assumes rx_regs_params.svh for all numeric constants.
 */
`default_nettype none

package rx_regs_pkg;

    // ===========================================================
    // serial target states
    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_ADDR_ACK,
        I2C_WR,
        I2C_WR_ACK,
        I2C_RD,
        I2C_RD_ACK
    } i2c_state_t;

    // live conditions raised by the firmware core
    typedef struct packed {
        logic [7:0] fault;
        logic [5:0] comm;
        logic [3:0] stream;
    } status_live_t;

    // settings handed to the power path
    typedef struct packed {
        logic [15:0] output_voltage_target;
        logic [7:0] current_limit_setting;
        logic [7:0] rectifier_threshold;
    } config_t;

    // state of the register bank outside the status banks and the pin synchroniser
    typedef struct packed {
        i2c_state_t phase;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic rw;
        logic [1:0] idx;
        logic [15:0] ptr;
        logic sda_oe;
        logic scl_q;
        logic sda_q;
        logic [5:0] cmd;
        logic out_on;
        logic [15:0] vout;
        logic [7:0] ilim;
        logic [7:0] rect_thr;
        logic [7:0] clr_fault;
        logic [5:0] clr_comm;
        logic [3:0] clr_stream;
    } host_regs_state_t;

endpackage

`default_nettype wire

//--- sync_2ff.sv
/*
 * Two flip-flop synchroniser for a group of pin levels.
 * Assumes the inputs are asynchronous to clk_sys.
 */
`default_nettype none

module sync_2ff #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second; idle bus level is high
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            meta <= '1;
            sync_out <= '1;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

`default_nettype wire

//--- event_status_bank.sv
/*
 * One status byte: live copy of the firmware conditions and a sticky
 * latch cleared by write-one pulses. Assumes live and clear are on clk_sys.
 */
`default_nettype none

module event_status_bank #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // conditions and clears
    input wire logic [WIDTH-1:0] live,
    input wire logic [WIDTH-1:0] clear,
    // register views
    output logic [WIDTH-1:0] status,
    output logic [WIDTH-1:0] latched
);

    // live view follows the condition; the latch keeps it, set beats clear
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            status <= '0;
            latched <= '0;
        end else begin
            status <= live;
            latched <= (latched & ~clear) | live;
        end
    end

    live_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ##1 status == $past(live))
        else $error("status byte does not follow live conditions");

    latch_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (clear & ~live) != '0 |=> (latched & $past(clear & ~live)) == '0)
        else $error("cleared latch bit still set");

    latch_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        live != '0 |=> (latched & $past(live)) == $past(live) [*1] ##1
        ((latched | $past(clear)) & $past(latched, 2) & $past(live, 2))
        == ($past(latched, 2) & $past(live, 2)))
        else $error("event lost from latch");

endmodule

`default_nettype wire

//--- rx_host_regs.sv
/*
 * Receive-mode host register bank behind an I2C target: status bytes,
 * latches with write-one clears, command register and output settings.
 * Assumes scl and sda come from pins; live, cmd_ack come from firmware logic
 * on clk_sys; the pad resolves the open-drain sda from sda_oe.
 */
`include "rx_regs_params.svh"
`default_nettype none

// Summary of operation
// - fault status bits 0-7: temp, current, voltage, error, short, message, on, off
// - comm status bits 0-5: sent, timeout, strength, rectified ready, removed, nack
// - stream status bits 0-3: send done, send timeout, receive done, receive timeout
// - command bit 0 switches the regulated output on
// - command bit 1 switches the regulated output off
// - both on and off set together: no action, both bits cleared
// - command bit 2 sends one custom packet from the payload registers
// - command bit 3 sends a custom packet and awaits a reply
// - command bit 4 sends an end of power transfer packet
// - command bit 5 starts a data-stream send from the payload registers
// - output voltage target is 16 bits, low byte then high byte, 25mV steps
// - current limit ranges 100mA to 2.5A in 100mA steps
// - rectifier auto-off threshold counts in 100mV steps
// - each event has a write-one clear bit for its latch
module rx_host_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h61
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // serial pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // firmware conditions and command acknowledges
    input wire rx_regs_pkg::status_live_t live,
    input wire logic [3:0] cmd_ack,
    // power path controls
    output logic output_active,
    output logic [3:0] cmd_request,
    output rx_regs_pkg::config_t cfg
);

    // ===========================================================
    // declarations
    localparam rx_regs_pkg::host_regs_state_t STATE_RST = '{
        phase: rx_regs_pkg::I2C_IDLE,
        scl_q: 1'b1,
        sda_q: 1'b1,
        vout: `VOUT_RST,
        ilim: `ILIM_RST,
        rect_thr: `RECT_THR_RST,
        default: '0
    };

    rx_regs_pkg::host_regs_state_t s;
    rx_regs_pkg::host_regs_state_t next_s;
    logic [1:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic [7:0] fault_status;
    logic [7:0] fault_latched;
    logic [5:0] comm_status;
    logic [5:0] comm_latched;
    logic [3:0] stream_status;
    logic [3:0] stream_latched;
    logic wr_now;
    logic [15:0] wr_addr;
    logic [7:0] wr_data;

    // ===========================================================
    // pin synchroniser and status bytes
    sync_2ff #(.WIDTH(2)) pin_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .async_in({scl_i, sda_i}),
        .sync_out(pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    event_status_bank #(.WIDTH(`FAULT_BITS)) fault_bank (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .live(live.fault),
        .clear(s.clr_fault),
        .status(fault_status),
        .latched(fault_latched)
    );

    event_status_bank #(.WIDTH(`COMM_BITS)) comm_bank (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .live(live.comm),
        .clear(s.clr_comm),
        .status(comm_status),
        .latched(comm_latched)
    );

    event_status_bank #(.WIDTH(`STREAM_BITS)) stream_bank (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .live(live.stream),
        .clear(s.clr_stream),
        .status(stream_status),
        .latched(stream_latched)
    );

    // ===========================================================
    // next state: serial target, register writes and command handling
    always_comb begin
        logic rise;
        logic fall;
        logic [7:0] rd_data;
        rise = scl_s & ~s.scl_q;
        fall = ~scl_s & s.scl_q;
        rd_data = 8'h00;
        next_s = s;
        next_s.scl_q = scl_s;
        next_s.sda_q = sda_s;
        next_s.clr_fault = '0;
        next_s.clr_comm = '0;
        next_s.clr_stream = '0;
        wr_now = 1'b0;
        wr_addr = s.ptr;
        wr_data = s.shreg;
        // read mux; reserved bits and unmapped offsets read zero
        case (s.ptr)
            `OFS_FAULT_LATCH: rd_data = fault_latched;
            `OFS_COMM_LATCH: rd_data = {2'h0, comm_latched};
            `OFS_STREAM_LATCH: rd_data = {4'h0, stream_latched};
            `OFS_FAULT_STATUS: rd_data = fault_status;
            `OFS_COMM_STATUS: rd_data = {2'h0, comm_status};
            `OFS_STREAM_STATUS: rd_data = {4'h0, stream_status};
            `OFS_COMMAND: rd_data = {2'h0, s.cmd};
            `OFS_VOUT_LOW: rd_data = s.vout[7:0];
            `OFS_VOUT_HIGH: rd_data = s.vout[15:8];
            `OFS_ILIM: rd_data = s.ilim;
            `OFS_RECT_THR: rd_data = s.rect_thr;
            default: rd_data = 8'h00;
        endcase
        // output switching acts on the held bits, then clears them
        if (s.cmd[`CMD_OUT_ON] && s.cmd[`CMD_OUT_OFF]) begin
            next_s.cmd[1:0] = 2'h0;
        end else if (s.cmd[`CMD_OUT_ON]) begin
            next_s.out_on = 1'b1;
            next_s.cmd[`CMD_OUT_ON] = 1'b0;
        end else if (s.cmd[`CMD_OUT_OFF]) begin
            next_s.out_on = 1'b0;
            next_s.cmd[`CMD_OUT_OFF] = 1'b0;
        end
        // firmware acknowledge drops a transmit request
        next_s.cmd[5:2] = s.cmd[5:2] & ~cmd_ack;
        // serial target
        case (s.phase)
            rx_regs_pkg::I2C_IDLE: begin
                next_s.sda_oe = 1'b0;
            end
            rx_regs_pkg::I2C_ADDR: begin
                if (rise) begin
                    next_s.shreg = {s.shreg[6:0], sda_s};
                    next_s.bitcnt = s.bitcnt + 4'h1;
                end else if (fall && s.bitcnt == 4'h8) begin
                    if (s.shreg[7:1] == DEV_ADDR) begin
                        next_s.sda_oe = 1'b1;
                        next_s.rw = s.shreg[0];
                        next_s.idx = 2'h0;
                        next_s.phase = rx_regs_pkg::I2C_ADDR_ACK;
                    end else begin
                        next_s.phase = rx_regs_pkg::I2C_IDLE;
                    end
                end
            end
            rx_regs_pkg::I2C_ADDR_ACK: begin
                if (fall && s.rw) begin
                    next_s.shreg = {rd_data[6:0], 1'b0};
                    next_s.sda_oe = ~rd_data[7];
                    next_s.bitcnt = 4'h1;
                    next_s.ptr = s.ptr + 16'h0001;
                    next_s.phase = rx_regs_pkg::I2C_RD;
                end else if (fall) begin
                    next_s.sda_oe = 1'b0;
                    next_s.bitcnt = 4'h0;
                    next_s.phase = rx_regs_pkg::I2C_WR;
                end
            end
            rx_regs_pkg::I2C_WR: begin
                if (rise) begin
                    next_s.shreg = {s.shreg[6:0], sda_s};
                    next_s.bitcnt = s.bitcnt + 4'h1;
                end else if (fall && s.bitcnt == 4'h8) begin
                    next_s.sda_oe = 1'b1;
                    next_s.phase = rx_regs_pkg::I2C_WR_ACK;
                    if (s.idx == 2'h0) begin
                        next_s.ptr[15:8] = s.shreg;
                        next_s.idx = 2'h1;
                    end else if (s.idx == 2'h1) begin
                        next_s.ptr[7:0] = s.shreg;
                        next_s.idx = 2'h2;
                    end else begin
                        wr_now = 1'b1;
                        next_s.ptr = s.ptr + 16'h0001;
                    end
                end
            end
            rx_regs_pkg::I2C_WR_ACK: begin
                if (fall) begin
                    next_s.sda_oe = 1'b0;
                    next_s.bitcnt = 4'h0;
                    next_s.phase = rx_regs_pkg::I2C_WR;
                end
            end
            rx_regs_pkg::I2C_RD: begin
                if (fall && s.bitcnt == 4'h8) begin
                    next_s.sda_oe = 1'b0;
                    next_s.phase = rx_regs_pkg::I2C_RD_ACK;
                end else if (fall) begin
                    next_s.sda_oe = ~s.shreg[7];
                    next_s.shreg = {s.shreg[6:0], 1'b0};
                    next_s.bitcnt = s.bitcnt + 4'h1;
                end
            end
            rx_regs_pkg::I2C_RD_ACK: begin
                if (rise) begin
                    next_s.phase = sda_s ? rx_regs_pkg::I2C_IDLE : rx_regs_pkg::I2C_ADDR_ACK;
                end
            end
            default: begin
                next_s.phase = rx_regs_pkg::I2C_IDLE;
            end
        endcase
        // register write; a new command bit wins over its acknowledge
        if (wr_now) begin
            case (wr_addr)
                `OFS_FAULT_CLEAR: next_s.clr_fault = wr_data;
                `OFS_COMM_CLEAR: next_s.clr_comm = wr_data[5:0];
                `OFS_STREAM_CLEAR: next_s.clr_stream = wr_data[3:0];
                `OFS_COMMAND: next_s.cmd = next_s.cmd | wr_data[5:0];
                `OFS_VOUT_LOW: next_s.vout[7:0] = wr_data;
                `OFS_VOUT_HIGH: next_s.vout[15:8] = wr_data;
                `OFS_ILIM: begin
                    if (wr_data < `ILIM_MIN_CODE) begin
                        next_s.ilim = `ILIM_MIN_CODE;
                    end else if (wr_data > `ILIM_MAX_CODE) begin
                        next_s.ilim = `ILIM_MAX_CODE;
                    end else begin
                        next_s.ilim = wr_data;
                    end
                end
                `OFS_RECT_THR: next_s.rect_thr = wr_data;
                default: begin
                end
            endcase
        end
        // start and stop override the bit engine
        if (scl_s && s.scl_q && s.sda_q && !sda_s) begin
            next_s.phase = rx_regs_pkg::I2C_ADDR;
            next_s.bitcnt = 4'h0;
            next_s.sda_oe = 1'b0;
        end else if (scl_s && s.scl_q && !s.sda_q && sda_s) begin
            next_s.phase = rx_regs_pkg::I2C_IDLE;
            next_s.sda_oe = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s <= STATE_RST;
        end else begin
            s <= next_s;
        end
    end

    // ===========================================================
    // outputs
    assign sda_o = 1'b0; // open drain: only ever pulls low
    assign sda_oe = s.sda_oe;
    assign output_active = s.out_on;
    assign cmd_request = s.cmd[5:2];
    assign cfg.output_voltage_target = s.vout;
    assign cfg.current_limit_setting = s.ilim;
    assign cfg.rectifier_threshold = s.rect_thr;

    // ===========================================================
    // checks
    both_cmds_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s.cmd[0] && s.cmd[1] |=> s.cmd[1:0] == 2'h0 && $stable(s.out_on))
        else $error("on and off together not discarded");

    output_on_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s.cmd[0] && !s.cmd[1] |=> output_active && !(s.cmd[0] && !$past(wr_now)))
        else $error("output not switched on");

    output_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !s.cmd[0] && s.cmd[1] |=> !output_active)
        else $error("output not switched off");

    send_held_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s.cmd[2] && !cmd_ack[0] |=> cmd_request[0])
        else $error("packet request dropped before acknowledge");

    cmd_issue_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wr_now && wr_addr == `OFS_COMMAND && wr_data[5] |=> cmd_request[3] [*1])
        else $error("stream send request not raised");

    cmd_self_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s.cmd[4] && cmd_ack[2] && !(wr_now && wr_addr == `OFS_COMMAND)
        |=> !s.cmd[4])
        else $error("command bit not cleared after acknowledge");

    vout_split_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wr_now && wr_addr == `OFS_VOUT_LOW
        |=> cfg.output_voltage_target[7:0] == $past(wr_data)
        && $stable(cfg.output_voltage_target[15:8]))
        else $error("voltage low byte write wrong");

    ilim_range_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ##1 s.ilim >= `ILIM_MIN_CODE && s.ilim <= `ILIM_MAX_CODE)
        else $error("current limit out of range");

endmodule

`default_nettype wire

//--- i2c_host_model.sv
/*
 * Behavioural I2C host that reaches the receive-mode register bank.
 * Assumes an open-drain sda resolved outside from sda_drv and the target.
 */
`default_nettype none

module i2c_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h61
) (
    // serial pins
    output logic scl,
    output logic sda_drv,
    input wire logic sda_line,
    // external supply handed to the receiver
    output logic ext_5v_en
);
    timeunit 1ns;
    timeprecision 100ps;

    // quarter of the 160 ns link period
    localparam int Q = 40;

    // bus idles high with the clock standing still
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        ext_5v_en = 1'b1;
    end

    // ===========================================================
    // bus conditions
    // wait out the target's synchroniser delay so a held ack is released before scl rises
    task automatic start_cond();
        sda_drv = 1'b1;
        #(2 * Q);
        scl = 1'b1;
        #Q;
        sda_drv = 1'b0;
        #Q;
        scl = 1'b0;
    endtask

    task automatic stop_cond();
        #Q;
        sda_drv = 1'b0;
        #Q;
        scl = 1'b1;
        #Q;
        sda_drv = 1'b1;
        #(2 * Q);
    endtask

    // one bit: data set mid low phase, sampled mid high phase
    task automatic xfer_bit(input logic b, output logic r);
        #Q;
        sda_drv = b;
        #Q;
        scl = 1'b1;
        #Q;
        r = sda_line;
        #Q;
        scl = 1'b0;
    endtask

    // eight bits MSB first, then the acknowledge slot
    task automatic xfer_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx);
        logic bt;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(tx[i], bt);
            rx[i] = bt;
        end
        xfer_bit(ack_in, bt);
    endtask

    // ===========================================================
    // register accesses
    task automatic write_reg(input logic [15:0] ptr, input logic [7:0] d);
        logic [7:0] rx;
        start_cond();
        xfer_byte({DEV_ADDR, 1'b0}, 1'b1, rx);
        xfer_byte(ptr[15:8], 1'b1, rx);
        xfer_byte(ptr[7:0], 1'b1, rx);
        xfer_byte(d, 1'b1, rx);
        stop_cond();
    endtask

    task automatic read_reg(input logic [15:0] ptr, output logic [7:0] d);
        logic [7:0] rx;
        start_cond();
        xfer_byte({DEV_ADDR, 1'b0}, 1'b1, rx);
        xfer_byte(ptr[15:8], 1'b1, rx);
        xfer_byte(ptr[7:0], 1'b1, rx);
        start_cond();
        xfer_byte({DEV_ADDR, 1'b1}, 1'b1, rx);
        xfer_byte(8'hFF, 1'b1, d);
        stop_cond();
    endtask

    // stream send; payload registers are left alone until the session ends
    task automatic start_stream();
        write_reg(16'h00A0, 8'h20);
    endtask

    // drop the external supply once transmitter removal is reported
    task automatic poll_removal();
        logic [7:0] d;
        read_reg(16'h009D, d);
        if (d[4]) begin
            ext_5v_en = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

//--- testbench.sv
/*
 * Self-checking bench of the receive-mode host register bank.
 * Assumes the host model above and rx_regs_params.svh offsets.
 */
`include "rx_regs_params.svh"
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys, rst_b, scl, sda_drv, sda_line, ext_5v_en;
    logic sda_o, sda_oe, output_active;
    logic [3:0] cmd_ack, cmd_request;
    logic [7:0] rd;
    rx_regs_pkg::status_live_t live;
    rx_regs_pkg::config_t cfg;
    int err_count, checks, cycles;

    // open-drain sda with pull-up
    assign sda_line = sda_drv & (~sda_oe | sda_o);

    rx_host_regs #(.DEV_ADDR(7'h61)) u_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .live(live), .cmd_ack(cmd_ack),
        .output_active(output_active), .cmd_request(cmd_request), .cfg(cfg));

    i2c_host_model #(.DEV_ADDR(7'h61)) u_host (
        .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line), .ext_5v_en(ext_5v_en));

    // ===========================================================
    // clock and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            err_count++;
            test_done();
        end
    end

    // ===========================================================
    // shared helpers
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_rd(input logic [15:0] ptr, input logic [7:0] wd, input logic [7:0] exp);
        u_host.write_reg(ptr, wd);
        u_host.read_reg(ptr, rd);
        check("readback", rd, exp);
    endtask

    task automatic rd_chk(input logic [15:0] ptr, input logic [7:0] exp);
        u_host.read_reg(ptr, rd);
        check("read", rd, exp);
    endtask

    task automatic ack_pulse(input logic [3:0] m);
        @(negedge clk_sys) cmd_ack = m;
        @(negedge clk_sys) cmd_ack = 4'h0;
        @(negedge clk_sys);
    endtask

    task automatic test_done();
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ===========================================================
    // scenarios
    task automatic t_reset();
        check("output_active", output_active, 1'h0);
        check("cmd_request", cmd_request, 4'h0);
        check("cfg", cfg, {16'h0000, 8'h0A, 8'h00});
        rd_chk(`OFS_ILIM, 8'h0A);
        rd_chk(16'h0050, 8'h00);
    endtask

    task automatic t_config();
        wr_rd(`OFS_VOUT_LOW, 8'h34, 8'h34);
        wr_rd(`OFS_VOUT_HIGH, 8'h12, 8'h12);
        check("vout target", cfg.output_voltage_target, 16'h1234);
        wr_rd(`OFS_ILIM, 8'h19, 8'h19);
        wr_rd(`OFS_ILIM, 8'h30, 8'h19);
        wr_rd(`OFS_ILIM, 8'h00, 8'h01);
        wr_rd(`OFS_ILIM, 8'h07, 8'h07);
        check("ilim", cfg.current_limit_setting, 8'h07);
        wr_rd(16'h00B3, 8'h2A, 8'h2A);
        check("threshold", cfg.rectifier_threshold, 8'h2A);
        wr_rd(`OFS_FAULT_STATUS, 8'hFF, 8'h00);
    endtask

    task automatic t_output();
        u_host.write_reg(`OFS_COMMAND, 8'h03);
        check("both while off", output_active, 1'h0);
        u_host.write_reg(`OFS_COMMAND, 8'h01);
        check("on", output_active, 1'h1);
        rd_chk(`OFS_COMMAND, 8'h00);
        u_host.write_reg(`OFS_COMMAND, 8'h03);
        check("both while on", output_active, 1'h1);
        rd_chk(`OFS_COMMAND, 8'h00);
        u_host.write_reg(`OFS_COMMAND, 8'h02);
        check("off", output_active, 1'h0);
    endtask

    task automatic t_commands();
        for (int i = 0; i < 3; i++) begin
            u_host.write_reg(`OFS_COMMAND, 8'h04 << i);
            check("request", cmd_request, 4'h1 << i);
            rd_chk(`OFS_COMMAND, 8'h04 << i);
            ack_pulse(4'h1 << i);
            check("request done", cmd_request, 4'h0);
        end
        u_host.start_stream();
        check("stream request", cmd_request, 4'h8);
        ack_pulse(4'h8);
        u_host.write_reg(`OFS_COMMAND, 8'h3C);
        check("all requests", cmd_request, 4'hF);
        ack_pulse(4'h5);
        check("partial ack", cmd_request, 4'hA);
        ack_pulse(4'hA);
        check("all done", cmd_request, 4'h0);
    endtask

    task automatic t_status();
        @(negedge clk_sys) live = {8'hA5, 6'h35, 4'h9};
        rd_chk(`OFS_FAULT_STATUS, 8'hA5);
        rd_chk(`OFS_COMM_STATUS, 8'h35);
        rd_chk(`OFS_STREAM_STATUS, 8'h09);
        u_host.poll_removal();
        check("ext supply", ext_5v_en, 1'h0);
        @(negedge clk_sys) live = '0;
        rd_chk(`OFS_COMM_STATUS, 8'h00);
        rd_chk(`OFS_COMM_LATCH, 8'h35);
        u_host.write_reg(`OFS_COMM_CLEAR, 8'h10);
        rd_chk(`OFS_COMM_LATCH, 8'h25);
        u_host.write_reg(`OFS_FAULT_CLEAR, 8'h05);
        rd_chk(`OFS_FAULT_LATCH, 8'hA0);
        u_host.write_reg(`OFS_STREAM_CLEAR, 8'h0F);
        rd_chk(`OFS_STREAM_LATCH, 8'h00);
    endtask

    // ===========================================================
    // main sequence
    initial begin
        rst_b = 1'b0;
        live = '0;
        cmd_ack = 4'h0;
        err_count = 0;
        checks = 0;
        cycles = 0;
        repeat (5) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (5) @(negedge clk_sys);
        t_reset();
        t_config();
        t_output();
        t_commands();
        t_status();
        test_done();
    end
endmodule

`default_nettype wire
